// ===== verilog/tsp_consts.svh
// Register offsets, field positions, reset values and codes of the test page.
// Assumes inclusion by bare name from design files only.
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define TSP_OFS_PROBE_SEL 8'h32
`define TSP_OFS_PIN_EN 8'h33
`define TSP_OFS_PIN_VAL 8'h34
`define TSP_OFS_PROBE_VIEW 8'h35
`define TSP_OFS_SELFTEST 8'h36
`define TSP_OFS_MISC 8'h31

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSP_BIT_REORDER 7
`define TSP_BIT_PRBS9 6
`define TSP_BIT_PRBS15 5
`define TSP_BIT_AUX_EN 7
`define TSP_BIT_GPIO_MODE 7
`define TSP_BIT_NLGAIN 6
`define TSP_BIT_SECCLK_D1 3

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define TSP_RST_PROBE_SEL 8'h00
`define TSP_RST_PIN_EN 8'h80
`define TSP_RST_PIN_VAL 8'h00
`define TSP_RST_SELFTEST 8'h40
`define TSP_RST_MISC 8'h00
`define TSP_SELFTEST_ARM 4'h9
`define TSP_SERIAL_PINS 5'h1f

`endif

// ===== verilog/tsp_pkg.sv
// Types shared by the test-page register block.
// Assumes nothing of its surroundings.
`default_nettype none
package tsp_pkg;
    typedef enum logic [1:0] {
        TSP_HOST_PAR = 2'b00,
        TSP_HOST_SPI = 2'b01,
        TSP_HOST_UART = 2'b10,
        TSP_HOST_I2C = 2'b11
    } tsp_host_t;

    typedef struct packed {
        logic [6:0] out;
        logic [6:0] oe_n;
    } tsp_pins_t;

    typedef struct packed {
        logic prbs9;
        logic prbs15;
        logic tx_start;
    } tsp_prbs_ctl_t;
endpackage
`default_nettype wire

// ===== verilog/tsp_prbs.sv
// Pseudo-random bit generator, PRBS9 or PRBS15.
// Assumes a same-clock start pulse and enable levels.
`default_nettype none
module tsp_prbs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire tsp_pkg::tsp_prbs_ctl_t ctl,
    output logic active,
    output logic bit_out
);
    logic [14:0] lfsr;
    logic run;
    logic en;
    logic en_q;
    logic fb;

    assign en = ctl.prbs9 | ctl.prbs15;
    assign fb = ctl.prbs9 ? (lfsr[8] ^ lfsr[4]) : (lfsr[14] ^ lfsr[13]);
    assign active = run;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfsr <= 15'h7fff;
            run <= 1'b0;
            en_q <= 1'b0;
            bit_out <= 1'b0;
        end else begin
            en_q <= en;
            if (en && !en_q) begin
                lfsr <= 15'h7fff;
                run <= 1'b0;
            end else if (!en) begin
                run <= 1'b0;
            end else if (ctl.tx_start) begin
                run <= 1'b1;
            end
            if (run && en) begin
                lfsr <= {lfsr[13:0], fb};
                bit_out <= ctl.prbs9 ? lfsr[8] : lfsr[14];
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/tsp_regs.sv
// Test-page registers: probe routing, PRBS control, GPIO on data pins.
// Assumes an AXI4-Lite master on aclk; pin inputs come from outside.
//
// The AXI4-Lite slave port was left to the implementer.
`include "tsp_consts.svh"
`default_nettype none
module tsp_regs #(
    parameter int GROUPS = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire tsp_pkg::tsp_host_t host_mode,
    input wire logic [GROUPS*8-1:0] probe_groups,
    input wire logic secure_clock,
    input wire logic tx_command,
    input wire logic selftest_command,
    input wire logic [6:0] pin_in,
    output tsp_pkg::tsp_pins_t pins,
    output logic uart_aux_output_line_en,
    output logic uart_request_line_en,
    output logic signal_output_pin,
    output logic receiver_nonlinear_gain,
    output logic selftest_start,
    output logic prbs_active,
    output logic prbs_bit
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] probe_and_prbs_select;
    logic [7:0] pin_driver_enable_control;
    logic [7:0] pin_gpio_value_control;
    logic [7:0] selftest_control;
    logic [7:0] misc_select;
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic do_write;
    logic wr_ok;
    logic aw_take;
    logic w_take;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_ok = (aw_addr == `TSP_OFS_PROBE_SEL) || (aw_addr == `TSP_OFS_PIN_EN)
        || (aw_addr == `TSP_OFS_PIN_VAL) || (aw_addr == `TSP_OFS_SELFTEST)
        || (aw_addr == `TSP_OFS_MISC) || (aw_addr == `TSP_OFS_PROBE_VIEW);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= {2'h0, s_axi_awaddr[7:2]};
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'h0 : 2'h3;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_en;
    assign wr_en = do_write && w_lane0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            probe_and_prbs_select <= `TSP_RST_PROBE_SEL;
            pin_driver_enable_control <= `TSP_RST_PIN_EN;
            pin_gpio_value_control <= `TSP_RST_PIN_VAL;
            selftest_control <= `TSP_RST_SELFTEST;
            misc_select <= `TSP_RST_MISC;
        end else if (wr_en) begin
            case (aw_addr)
                `TSP_OFS_PROBE_SEL: probe_and_prbs_select <= w_data;
                `TSP_OFS_PIN_EN: pin_driver_enable_control <= w_data;
                `TSP_OFS_PIN_VAL: pin_gpio_value_control <= w_data;
                `TSP_OFS_SELFTEST: selftest_control <= w_data & 8'h4f;
                `TSP_OFS_MISC: misc_select <= w_data & 8'h0f;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= 7'h00;
            pin_s2 <= 7'h00;
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
        end
    end

    // ----------------------------------------
    // Probe bus
    // ----------------------------------------
    logic [4:0] probe_group_select;
    logic [7:0] probe_bus;
    logic [6:0] probe_pins;
    logic probe_bus_reorder;
    logic [2:0] probe_bit_select;

    assign probe_group_select = probe_and_prbs_select[4:0];
    assign probe_bus_reorder = probe_and_prbs_select[`TSP_BIT_REORDER];
    assign probe_bit_select = misc_select[2:0];
    assign probe_bus = (32'(probe_group_select) < GROUPS) ?
        probe_groups[probe_group_select*8 +: 8] : 8'h00;

    // Reordered: pin k carries probe bit listed at position k of the order
    assign probe_pins = probe_bus_reorder ?
        {probe_bus[1], probe_bus[0], probe_bus[5], probe_bus[6],
         probe_bus[2], probe_bus[3], probe_bus[4]} : probe_bus[6:0];

    // ----------------------------------------
    // Pin control
    // ----------------------------------------
    logic serial_host;
    logic uart_aux_lines_enable;
    logic pin_gpio_mode;
    logic secure_clock_on_pin1;
    logic secure_d1;
    logic [6:0] pin_driver_enables;
    logic [6:0] pin_gpio_levels;
    logic [6:0] usable;
    logic [6:0] gpio_oe;
    logic gpio_on;

    assign serial_host = host_mode != tsp_pkg::TSP_HOST_PAR;
    assign uart_aux_lines_enable = pin_driver_enable_control[`TSP_BIT_AUX_EN];
    assign pin_gpio_mode = pin_gpio_value_control[`TSP_BIT_GPIO_MODE];
    assign secure_clock_on_pin1 = misc_select[`TSP_BIT_SECCLK_D1];
    assign pin_driver_enables = pin_driver_enable_control[6:0];
    assign pin_gpio_levels = pin_gpio_value_control[6:0];
    assign secure_d1 = secure_clock_on_pin1 && serial_host;
    assign usable = ((host_mode == tsp_pkg::TSP_HOST_SPI) ||
        ((host_mode == tsp_pkg::TSP_HOST_UART) && uart_aux_lines_enable)) ?
        {2'b00, `TSP_SERIAL_PINS} : 7'h7f;
    assign gpio_on = pin_gpio_mode && serial_host;
    assign gpio_oe = serial_host ? (pin_driver_enables & usable & {5'h1f, !secure_d1, 1'b1})
        : 7'h00;
    assign uart_aux_output_line_en = uart_aux_lines_enable;
    assign uart_request_line_en = uart_aux_lines_enable;

    logic [6:0] next_out;
    logic [6:0] next_oe;
    always_comb begin
        next_out = gpio_on ? pin_gpio_levels : probe_pins;
        next_oe = gpio_oe;
        if (secure_d1) begin
            next_out[1] = secure_clock;
            next_oe[1] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins.out <= 7'h00;
            pins.oe_n <= 7'h7f;
            signal_output_pin <= 1'b0;
            receiver_nonlinear_gain <= 1'b0;
            selftest_start <= 1'b0;
        end else begin
            pins.out <= next_out;
            pins.oe_n <= ~next_oe;
            signal_output_pin <= probe_bus[probe_bit_select];
            receiver_nonlinear_gain <= selftest_control[`TSP_BIT_NLGAIN];
            selftest_start <= selftest_command &&
                (selftest_control[3:0] == `TSP_SELFTEST_ARM);
        end
    end

    // ----------------------------------------
    // PRBS generator
    // ----------------------------------------
    tsp_pkg::tsp_prbs_ctl_t prbs_ctl;
    assign prbs_ctl.prbs9 = probe_and_prbs_select[`TSP_BIT_PRBS9];
    assign prbs_ctl.prbs15 = probe_and_prbs_select[`TSP_BIT_PRBS15] &&
        !probe_and_prbs_select[`TSP_BIT_PRBS9];
    assign prbs_ctl.tx_start = tx_command;

    tsp_prbs u_prbs (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctl(prbs_ctl),
        .active(prbs_active),
        .bit_out(prbs_bit)
    );

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    logic [7:0] rd_addr;
    logic [7:0] rd_val;

    assign s_axi_arready = !s_axi_rvalid;
    // Register index from the word address
    assign rd_addr = {2'h0, s_axi_araddr[7:2]};

    always_comb begin
        rd_val = 8'h00;
        case (rd_addr)
            `TSP_OFS_PROBE_SEL: rd_val = probe_and_prbs_select;
            `TSP_OFS_PIN_EN: rd_val = pin_driver_enable_control;
            `TSP_OFS_PIN_VAL: rd_val = pin_gpio_mode ? {1'b1, pin_s2}
                : pin_gpio_value_control;
            `TSP_OFS_PROBE_VIEW: rd_val = probe_bus;
            `TSP_OFS_SELFTEST: rd_val = selftest_control;
            `TSP_OFS_MISC: rd_val = misc_select;
            default: rd_val = 8'h00;
        endcase
    end

    logic rd_hit;
    assign rd_hit = (rd_addr == `TSP_OFS_PROBE_SEL) || (rd_addr == `TSP_OFS_PIN_EN)
        || (rd_addr == `TSP_OFS_PIN_VAL) || (rd_addr == `TSP_OFS_PROBE_VIEW)
        || (rd_addr == `TSP_OFS_SELFTEST) || (rd_addr == `TSP_OFS_MISC);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h3;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== dv/tsp_regs_props.sv
// Concurrent checks on the test-page register block ports.
// Assumes a bind to tsp_regs on its single clock.
`default_nettype none
module tsp_regs_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire tsp_pkg::tsp_host_t host_mode,
    input wire logic tx_command,
    input wire logic selftest_command,
    input wire tsp_pkg::tsp_pins_t pins,
    input wire logic uart_aux_output_line_en,
    input wire logic uart_request_line_en,
    input wire logic selftest_start,
    input wire logic prbs_active
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_aux_rst;
        disable iff (1'b0) !aresetn |=> uart_aux_output_line_en && pins.oe_n == 7'h7f;
    endproperty
    property p_aux_pair;
        $changed(uart_aux_output_line_en) |->
            s_axi_bvalid && uart_aux_output_line_en == uart_request_line_en;
    endproperty
    property p_par_off;
        host_mode == tsp_pkg::TSP_HOST_PAR |=> pins.oe_n == 7'h7f;
    endproperty
    property p_five_pins;
        host_mode == tsp_pkg::TSP_HOST_SPI
            || (host_mode == tsp_pkg::TSP_HOST_UART && uart_aux_output_line_en)
            |=> pins.oe_n[6:5] == 2'h3;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_st_cause;
        selftest_start |-> $past(selftest_command);
    endproperty
    property p_tx_cause;
        $rose(prbs_active) |-> $past(tx_command);
    endproperty
    a_aux_rst: assert property (p_aux_rst) else $error("reset state wrong");
    a_aux_pair: assert property (p_aux_pair) else $error("uart enables differ");
    a_par_off: assert property (p_par_off) else $error("pin driven on parallel host");
    a_five_pins: assert property (p_five_pins) else $error("D5 or D6 driven");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    a_st_cause: assert property (p_st_cause) else $error("self-test without command");
    a_tx_cause: assert property (p_tx_cause) else $error("sequence without command");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_selftest: cover property (selftest_start);
    c_prbs: cover property ($rose(prbs_active));
endmodule
bind tsp_regs tsp_regs_props i_props (
    .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .host_mode, .tx_command, .selftest_command, .pins,
    .uart_aux_output_line_en, .uart_request_line_en, .selftest_start, .prbs_active
);
`default_nettype wire

// ===== dv/tsp_pin_model.sv
// Outside circuitry on the seven data pins.
// Assumes the device drives a pin when its oe_n bit is low.
`default_nettype none
module tsp_pin_model (
    input wire logic aclk,
    input wire tsp_pkg::tsp_pins_t pins,
    input wire logic [6:0] ext_en,
    input wire logic [6:0] ext_val,
    output logic [6:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Wire levels
    // ----------------------------------------
    logic [6:0] churn = 7'h55;
    always @(posedge aclk)
        churn <= ~churn;
    // Floating pins change every cycle
    always_comb
        for (int i = 0; i < 7; i++)
            pin_in[i] = !pins.oe_n[i] ? pins.out[i] : ext_en[i] ? ext_val[i] : churn[i];
endmodule
`default_nettype wire

// ===== dv/tb_tsp_regs.sv
// Self-checking bench of the test-page register block.
// Assumes tsp_regs, the pin model and the bound checker.
`default_nettype none
module tb_tsp_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, e;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    tsp_pkg::tsp_host_t host_mode = tsp_pkg::TSP_HOST_SPI;
    logic [255:0] probe_groups;
    logic secure_clock = 1'b0, tx_command = 1'b0, selftest_command = 1'b0;
    logic [6:0] pin_in, ext_en = 7'h00, ext_val = 7'h00;
    tsp_pkg::tsp_pins_t pins;
    logic uart_aux_output_line_en, uart_request_line_en, signal_output_pin;
    logic receiver_nonlinear_gain, selftest_start, prbs_active, prbs_bit;
    logic [39:0] s;
    int err_total = 0;
    int checks_done = 0;
    logic [23:0] rows [6] = '{24'hc8a5a5, 24'hd40098, 24'hcc3c3c, 24'hd8ff4f, 24'hd01515,
        24'hc40303};
    logic [23:0] hm [5] = '{24'h027f00, 24'h01ff60, 24'h02ff60, 24'h007f7f, 24'h03057a};
    tsp_regs i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_mode, .probe_groups,
        .secure_clock, .tx_command, .selftest_command, .pin_in, .pins,
        .uart_aux_output_line_en, .uart_request_line_en, .signal_output_pin,
        .receiver_nonlinear_gain, .selftest_start, .prbs_active, .prbs_bit
    );
    tsp_pin_model i_pins (.aclk, .pins, .ext_en, .ext_val, .pin_in);
    initial forever #4 aclk = ~aclk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] gv(input int n);
        return 8'(n * 29 + 7);
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic lim(input logic hung);
        if (hung) begin
            err_total++;
            stop_test();
        end
    endtask
    task automatic wt(ref logic sig);
        int n;
        n = 0;
        @(negedge aclk);
        while (sig !== 1'b1 && n < 40) begin
            @(negedge aclk);
            n++;
        end
        lim(sig !== 1'b1);
        checks_done++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        logic pa, pw, ta, tw;
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        n = 0;
        while ((pa || pw) && n < 40) begin
            @(negedge aclk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
            n++;
        end
        lim(pa || pw);
        wt(s_axi_bvalid);
        chk(32'(s_axi_bresp), 32'(er));
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        wt(s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        wt(s_axi_rvalid);
        d = s_axi_rdata;
        chk(32'(s_axi_rresp), 32'(er));
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        for (int g = 0; g < 32; g++)
            probe_groups[g*8+:8] = gv(g);
        do_reset();
        for (int i = 0; i < 6; i++) begin
            wr(rows[i][23:16], rows[i][15:8], 2'h0);
            rd(rows[i][23:16], 2'h0);
            chk(d, {24'h0, rows[i][7:0]});
        end
        $display("test registers done");
        wr(8'h40, 8'h12, 2'h3);
        rd(8'h40, 2'h3);
        $display("test unmapped done");
        for (int i = 0; i < 5; i++) begin
            @(posedge aclk);
            host_mode <= tsp_pkg::tsp_host_t'(hm[i][17:16]);
            wr(8'hcc, hm[i][15:8], 2'h0);
            repeat (3) @(negedge aclk);
            chk(32'(pins.oe_n), 32'(hm[i][6:0]));
            chk(32'(uart_aux_output_line_en), 32'(hm[i][15]));
        end
        $display("test host modes done");
        @(posedge aclk);
        host_mode <= tsp_pkg::TSP_HOST_UART;
        e = gv(12);
        wr(8'hcc, 8'h7f, 2'h0);
        wr(8'hc8, 8'h8c, 2'h0);
        repeat (3) @(negedge aclk);
        chk(32'(pins.out), 32'({e[1], e[0], e[5], e[6], e[2], e[3], e[4]}));
        wr(8'hc8, 8'h0c, 2'h0);
        repeat (3) @(negedge aclk);
        chk(32'(pins.out), 32'(e[6:0]));
        chk(32'(signal_output_pin), 32'(e[3]));
        $display("test reorder done");
        @(posedge aclk);
        host_mode <= tsp_pkg::TSP_HOST_I2C;
        ext_en <= 7'h70;
        ext_val <= 7'h50;
        wr(8'hcc, 8'h0f, 2'h0);
        wr(8'hd0, 8'haa, 2'h0);
        repeat (3) @(negedge aclk);
        chk(32'(pins.oe_n), 32'h70);
        chk(32'(pins.out[3:0]), 32'ha);
        rd(8'hd0, 2'h0);
        chk(d, 32'hda);
        wr(8'hc4, 8'h08, 2'h0);
        repeat (3) @(negedge aclk);
        chk(32'(pins.out[1]), 32'h0);
        $display("test gpio done");
        wr(8'hd8, 8'h00, 2'h0);
        repeat (2) @(negedge aclk);
        chk(32'(receiver_nonlinear_gain), 32'h0);
        wr(8'hd8, 8'h49, 2'h0);
        selftest_command <= 1'b1;
        @(posedge aclk);
        selftest_command <= 1'b0;
        wt(selftest_start);
        chk(32'(receiver_nonlinear_gain), 32'h1);
        wr(8'hd8, 8'h48, 2'h0);
        selftest_command <= 1'b1;
        @(posedge aclk);
        selftest_command <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(negedge aclk);
            chk(32'(selftest_start), 32'h0);
        end
        $display("test selftest done");
        @(posedge aclk);
        do_reset();
        @(negedge aclk);
        chk(32'(pins.oe_n), 32'h7f);
        rd(8'hcc, 2'h0);
        chk(d, 32'h80);
        rd(8'hd8, 2'h0);
        chk(d, 32'h40);
        $display("test reset done");
        for (int k = 0; k < 2; k++) begin
            do_reset();
            wr(8'hc8, k ? 8'h20 : 8'h40, 2'h0);
            repeat (3) @(negedge aclk);
            chk(32'(prbs_active), 32'h0);
            @(posedge aclk);
            tx_command <= 1'b1;
            @(posedge aclk);
            tx_command <= 1'b0;
            wt(prbs_active);
            for (int i = 0; i < 40; i++) begin
                @(negedge aclk);
                s[i] = prbs_bit;
            end
            chk(32'(|s), 32'h1);
            for (int i = 15; i < 40; i++)
                chk(32'(s[i]), 32'(s[i-(k ? 15 : 9)] ^ s[i-(k ? 14 : 5)]));
            @(posedge aclk);
        end
        $display("test prbs done");
        stop_test();
    end
endmodule
`default_nettype wire
